// file: mad_pkg.sv
package mad_pkg;
   // ***********************************************
   // Widths
   // ***********************************************
   localparam int unsigned WORD_W = 16;
   localparam int unsigned PROD_W = 32;
   localparam int unsigned ACC_W = 36;
   localparam int unsigned WS_W = 4;
   localparam int unsigned CNT_W = 5;

   // ***********************************************
   // Field positions and constants
   // ***********************************************
   localparam int unsigned CTRL_W = 3;
   localparam int unsigned CTRL_CLR0_BIT = 0;    // Clear-inhibit for accumulator 0
   localparam int unsigned CTRL_CLR1_BIT = 1;    // Clear-inhibit for accumulator 1
   localparam int unsigned CTRL_SQR_BIT = 2;     // Square-mirror enable
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
   localparam logic [ACC_W-1:0] RND_ADD = 36'h000008000;
   localparam logic [ACC_W-1:0] INCH_ADD = 36'h000010000;
   localparam logic [ACC_W-1:0] ONE = 36'h000000001;
   localparam logic [CNT_W-1:0] CYC_LOAD = 5'h1;   // Cycles for no transfer or a load
   localparam logic [CNT_W-1:0] CYC_STORE = 5'h2;  // Cycles for a store transfer
   localparam logic [CNT_W-1:0] CYC_BANK = 5'h1;   // Same-bank conflict penalty

   // ***********************************************
   // Function statements and special functions
   // ***********************************************
   typedef enum logic [4:0] {
      F_NONE = 5'h00, F_MUL = 5'h01, F_LDP = 5'h02, F_ADDP = 5'h03, F_SUBP = 5'h04,
      F_LDY = 5'h05, F_ADDY = 5'h06, F_SUBY = 5'h07, F_ANDY = 5'h08, F_ORY = 5'h09,
      F_XORY = 5'h0A, S_SHR1 = 5'h10, S_SHR4 = 5'h11, S_SHR8 = 5'h12, S_SHR16 = 5'h13,
      S_SHL1 = 5'h14, S_SHL4 = 5'h15, S_SHL8 = 5'h16, S_SHL16 = 5'h17, S_COPY = 5'h18,
      S_NEG = 5'h19, S_NOT = 5'h1A, S_RND = 5'h1B, S_INCH = 5'h1C, S_INC = 5'h1D,
      S_LDY = 5'h1E, S_LDP = 5'h1F
   } mad_func_t;

   // Second operand width for y-based ALU functions
   typedef enum logic [1:0] {
      OPW_16 = 2'h0, OPW_32 = 2'h1, OPW_36 = 2'h2
   } mad_opw_t;

   // ***********************************************
   // Transfer statements
   // ***********************************************
   typedef enum logic [3:0] {
      X_NONE = 4'h0, X_YH = 4'h1, X_YL = 4'h2, X_AH = 4'h3, X_AL = 4'h4,
      X_X = 4'h5, X_YH_X = 4'h6, X_ST_Y = 4'h7, X_ST_A = 4'h8
   } mad_xfer_t;

   // ***********************************************
   // Conditions for special functions
   // ***********************************************
   typedef enum logic [2:0] {
      C_TRUE = 3'h0, C_EQ = 3'h1, C_NE = 3'h2, C_MI = 3'h3,
      C_PL = 3'h4, C_CTR = 3'h5, C_RAND = 3'h6, C_LV = 3'h7
   } mad_cond_t;

   // ***********************************************
   // Sequencing states (Gray coded)
   // ***********************************************
   typedef enum logic [0:0] {
      ST_READY = 1'h0, ST_HOLD = 1'h1
   } mad_state_t;
endpackage

// file: mad_mult.sv
`timescale 1ns/1ps
module mad_mult (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Operands and strobe
   input wire logic mul_i,
   input wire logic signed [mad_pkg::WORD_W-1:0] opa_i,
   input wire logic signed [mad_pkg::WORD_W-1:0] opb_i,
   // Product register
   output logic signed [mad_pkg::PROD_W-1:0] prod_o
);
   logic signed [mad_pkg::PROD_W-1:0] next_prod;

   // Signed 16x16 multiply into the product register
   always_comb begin
      next_prod = prod_o;
      if (mul_i) begin
         next_prod = opa_i * opb_i;
      end
   end

   // Product register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         prod_o <= '0;
      end else begin
         prod_o <= next_prod;
      end
   end
endmodule // mad_mult

// file: mad_datapath.sv
`timescale 1ns/1ps
module mad_datapath (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Instruction from the sequencer
   input wire logic instr_valid_i,
   input wire mad_pkg::mad_func_t func_i,
   input wire logic mul_i,
   input wire logic src_acc_i,
   input wire logic dst_acc_i,
   input wire mad_pkg::mad_opw_t opw_i,
   input wire mad_pkg::mad_cond_t cond_i,
   input wire mad_pkg::mad_xfer_t xfer_i,
   input wire logic xfer_acc_i,
   // Memory data and access attributes
   input wire logic [mad_pkg::WORD_W-1:0] ram_rdata_i,
   input wire logic [mad_pkg::WORD_W-1:0] table_rdata_i,
   input wire logic pc_ext_i,
   input wire logic table_ext_i,
   input wire logic ram_ext_i,
   input wire logic same_bank_i,
   input wire logic [mad_pkg::WS_W-1:0] wait_states_i,
   // Condition sources
   input wire logic counter_cond_i,
   input wire logic random_bit_i,
   input wire logic bmu_update_i,
   input wire logic [2:0] bmu_flags_i,
   // Arithmetic control register load
   input wire logic ctrl_we_i,
   input wire logic [mad_pkg::CTRL_W-1:0] ctrl_wdata_i,
   // Status and results
   output logic ready_o,
   output logic done_o,
   output logic table_ptr_inc_o,
   output logic ram_we_o,
   output logic [mad_pkg::WORD_W-1:0] ram_wdata_o,
   output logic [mad_pkg::ACC_W-1:0] acc0_o,
   output logic [mad_pkg::ACC_W-1:0] acc1_o,
   output logic [mad_pkg::PROD_W-1:0] prod_o,
   output logic [2:0] flags_o,
   output logic [mad_pkg::CTRL_W-1:0] ctrl_o
);
   // ***********************************************
   // Declarations
   // ***********************************************
   logic [mad_pkg::ACC_W-1:0] acc [2];
   logic [mad_pkg::ACC_W-1:0] next_acc [2];
   logic [mad_pkg::WORD_W-1:0] opa, opb_hi, opb_lo;
   logic [mad_pkg::WORD_W-1:0] next_opa, next_opb_hi, next_opb_lo;
   logic [2:0] next_flags;                   // {overflow, negative, zero}
   logic [mad_pkg::CTRL_W-1:0] next_ctrl;
   mad_pkg::mad_state_t state, next_state;
   logic [mad_pkg::CNT_W-1:0] remain, next_remain;
   logic next_done, next_tinc, next_we;
   logic [mad_pkg::WORD_W-1:0] next_wdata;
   logic take;
   logic [mad_pkg::ACC_W-1:0] as, pext, yext, opnd, res, wide;
   logic uses_table, uses_ram, is_spec, cond_ok, wr_acc, ovf;
   logic [mad_pkg::CNT_W-1:0] cycles;
   logic signed [mad_pkg::PROD_W-1:0] prod;

   // Product register, loaded from the operands held before this instruction
   mad_mult u_mult (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .mul_i(take && mul_i),
      .opa_i(opa),
      .opb_i(opb_hi),
      .prod_o(prod)
   );

   assign take = instr_valid_i && (state == mad_pkg::ST_READY);

   // ***********************************************
   // Function statement and special function
   // ***********************************************
   always_comb begin
      as = acc[src_acc_i];
      pext = {{(mad_pkg::ACC_W-mad_pkg::PROD_W){prod[mad_pkg::PROD_W-1]}}, prod};
      yext = {{(mad_pkg::ACC_W-mad_pkg::PROD_W){opb_hi[mad_pkg::WORD_W-1]}}, opb_hi, opb_lo};
      case (opw_i)
         mad_pkg::OPW_16: opnd = {{(mad_pkg::ACC_W-mad_pkg::PROD_W){opb_hi[mad_pkg::WORD_W-1]}},
                                  opb_hi, {mad_pkg::WORD_W{1'b0}}};
         mad_pkg::OPW_36: opnd = acc[~src_acc_i];
         default: opnd = yext;
      endcase
      wide = {mad_pkg::ACC_W{1'b0}};
      wr_acc = 1'b1;
      ovf = 1'b0;
      case (func_i)
         mad_pkg::F_LDP, mad_pkg::S_LDP: res = pext;
         mad_pkg::F_ADDP: res = as + pext;
         mad_pkg::F_SUBP: res = as - pext;
         mad_pkg::F_LDY, mad_pkg::S_LDY: res = yext;
         mad_pkg::F_ADDY: res = as + opnd;
         mad_pkg::F_SUBY: res = as - opnd;
         mad_pkg::F_ANDY: res = as & opnd;
         mad_pkg::F_ORY: res = as | opnd;
         mad_pkg::F_XORY: res = as ^ opnd;
         mad_pkg::S_SHR1: res = $signed(as) >>> 1;
         mad_pkg::S_SHR4: res = $signed(as) >>> 4;
         mad_pkg::S_SHR8: res = $signed(as) >>> 8;
         mad_pkg::S_SHR16: res = $signed(as) >>> 16;
         mad_pkg::S_SHL1, mad_pkg::S_SHL4, mad_pkg::S_SHL8, mad_pkg::S_SHL16: begin
            wide = as << (func_i == mad_pkg::S_SHL1 ? 1 : func_i == mad_pkg::S_SHL4 ? 4 :
                          func_i == mad_pkg::S_SHL8 ? 8 : 16);
            res = {{(mad_pkg::ACC_W-mad_pkg::PROD_W){wide[mad_pkg::PROD_W-1]}},
                   wide[mad_pkg::PROD_W-1:0]};
         end
         mad_pkg::S_COPY: res = as;
         mad_pkg::S_NEG: res = ~as + mad_pkg::ONE;
         mad_pkg::S_NOT: res = ~as;
         mad_pkg::S_RND: res = (as + mad_pkg::RND_ADD) & ~{{(mad_pkg::ACC_W-mad_pkg::WORD_W){1'b0}},
                                                           {mad_pkg::WORD_W{1'b1}}};
         mad_pkg::S_INCH: res = {as[mad_pkg::ACC_W-1:mad_pkg::WORD_W] + 20'h00001, {mad_pkg::WORD_W{1'b0}}};
         mad_pkg::S_INC: res = as + mad_pkg::ONE;
         default: begin
            res = as;
            wr_acc = 1'b0;                                          // No function or multiply only
         end
      endcase
      // Overflow: sign into the guard bits disagrees with bit 35
      ovf = (res[mad_pkg::ACC_W-1] != res[mad_pkg::PROD_W-1]) ? 1'b1 : 1'b0;
   end

   // Condition evaluation for special functions
   always_comb begin
      is_spec = func_i[4];
      case (cond_i)
         mad_pkg::C_EQ: cond_ok = flags_o[0];
         mad_pkg::C_NE: cond_ok = ~flags_o[0];
         mad_pkg::C_MI: cond_ok = flags_o[1];
         mad_pkg::C_PL: cond_ok = ~flags_o[1];
         mad_pkg::C_CTR: cond_ok = counter_cond_i;
         mad_pkg::C_RAND: cond_ok = random_bit_i;
         mad_pkg::C_LV: cond_ok = flags_o[2];
         default: cond_ok = 1'b1;
      endcase
      if (!is_spec) begin
         cond_ok = 1'b1;
      end
   end

   // ***********************************************
   // Cycle count of the instruction
   // ***********************************************
   always_comb begin
      uses_table = (xfer_i == mad_pkg::X_X) || (xfer_i == mad_pkg::X_YH_X);
      uses_ram = (xfer_i != mad_pkg::X_NONE) && (xfer_i != mad_pkg::X_X);
      cycles = mad_pkg::CYC_LOAD;
      if ((xfer_i == mad_pkg::X_ST_Y) || (xfer_i == mad_pkg::X_ST_A)) begin
         cycles = mad_pkg::CYC_STORE;
      end
      if (pc_ext_i || (uses_table && table_ext_i) || (uses_ram && ram_ext_i)) begin
         cycles = cycles + {1'b0, wait_states_i};
      end
      if (uses_table && uses_ram && same_bank_i) begin
         cycles = cycles + mad_pkg::CYC_BANK;
      end
   end

   // ***********************************************
   // Datapath state update
   // ***********************************************
   always_comb begin
      next_acc = acc;
      next_opa = opa;
      next_opb_hi = opb_hi;
      next_opb_lo = opb_lo;
      next_flags = flags_o;
      next_ctrl = ctrl_o;
      next_tinc = 1'b0;
      next_we = 1'b0;
      next_wdata = ram_wdata_o;
      if (ctrl_we_i) begin
         next_ctrl = ctrl_wdata_i;
      end
      if (bmu_update_i) begin
         next_flags = bmu_flags_i;
      end
      if (take) begin
         // Function part, skipped when its condition fails
         if (wr_acc && cond_ok) begin
            next_acc[dst_acc_i] = res;
            next_flags = {ovf, res[mad_pkg::ACC_W-1], (res == '0)};
         end
         // Transfer part, wins over the function on the same accumulator
         case (xfer_i)
            mad_pkg::X_YH, mad_pkg::X_YH_X: begin
               next_opb_hi = ram_rdata_i;
               if (ctrl_o[mad_pkg::CTRL_SQR_BIT]) begin
                  next_opa = ram_rdata_i;
               end else if (xfer_i == mad_pkg::X_YH_X) begin
                  next_opa = table_rdata_i;
               end
               next_tinc = (xfer_i == mad_pkg::X_YH_X);
            end
            mad_pkg::X_YL: next_opb_lo = ram_rdata_i;
            mad_pkg::X_AH: begin
               next_acc[xfer_acc_i][mad_pkg::ACC_W-1:mad_pkg::WORD_W] =
                  {{(mad_pkg::ACC_W-mad_pkg::PROD_W){ram_rdata_i[mad_pkg::WORD_W-1]}}, ram_rdata_i};
               if (!ctrl_o[xfer_acc_i ? mad_pkg::CTRL_CLR1_BIT : mad_pkg::CTRL_CLR0_BIT]) begin
                  next_acc[xfer_acc_i][mad_pkg::WORD_W-1:0] = '0;
               end
            end
            mad_pkg::X_AL: next_acc[xfer_acc_i][mad_pkg::WORD_W-1:0] = ram_rdata_i;
            mad_pkg::X_X: begin
               next_opa = table_rdata_i;
               next_tinc = 1'b1;
            end
            mad_pkg::X_ST_Y: begin
               next_we = 1'b1;
               next_wdata = opb_hi;
            end
            mad_pkg::X_ST_A: begin
               next_we = 1'b1;
               next_wdata = acc[xfer_acc_i][mad_pkg::PROD_W-1:mad_pkg::WORD_W];
            end
            default: ;
         endcase
      end
   end

   // Datapath registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         acc[0] <= '0;
         acc[1] <= '0;
         opa <= '0;
         opb_hi <= '0;
         opb_lo <= '0;
         flags_o <= 3'h0;
         ctrl_o <= mad_pkg::CTRL_RST;
         table_ptr_inc_o <= 1'b0;
         ram_we_o <= 1'b0;
         ram_wdata_o <= '0;
      end else begin
         acc <= next_acc;
         opa <= next_opa;
         opb_hi <= next_opb_hi;
         opb_lo <= next_opb_lo;
         flags_o <= next_flags;
         ctrl_o <= next_ctrl;
         table_ptr_inc_o <= next_tinc;
         ram_we_o <= next_we;
         ram_wdata_o <= next_wdata;
      end
   end

   // ***********************************************
   // Instruction sequencing
   // ***********************************************
   always_comb begin
      next_state = state;
      next_remain = remain;
      next_done = 1'b0;
      case (state)
         mad_pkg::ST_READY: begin
            if (take) begin
               if (cycles == mad_pkg::CYC_LOAD) begin
                  next_done = 1'b1;
               end else begin
                  next_state = mad_pkg::ST_HOLD;
                  next_remain = cycles - mad_pkg::CYC_LOAD;
               end
            end
         end
         mad_pkg::ST_HOLD: begin
            next_remain = remain - mad_pkg::CYC_LOAD;
            if (remain == mad_pkg::CYC_LOAD) begin
               next_state = mad_pkg::ST_READY;
               next_done = 1'b1;
            end
         end
         default: next_state = mad_pkg::ST_READY;
      endcase
   end

   // Sequencing registers and mirrored outputs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= mad_pkg::ST_READY;
         remain <= '0;
         done_o <= 1'b0;
         ready_o <= 1'b1;
         acc0_o <= '0;
         acc1_o <= '0;
         prod_o <= '0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         done_o <= next_done;
         ready_o <= (next_state == mad_pkg::ST_READY);
         acc0_o <= next_acc[0];
         acc1_o <= next_acc[1];
         prod_o <= (take && mul_i) ? ($signed(opa) * $signed(opb_hi)) : prod;
      end
   end
endmodule // mad_datapath

// file: mad_chk.sv
`timescale 1ns/1ps
module mad_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Instruction and attributes
   input wire logic instr_valid_i,
   input wire mad_pkg::mad_func_t func_i,
   input wire mad_pkg::mad_xfer_t xfer_i,
   input wire logic xfer_acc_i,
   input wire logic [mad_pkg::WORD_W-1:0] ram_rdata_i,
   input wire logic pc_ext_i,
   input wire logic table_ext_i,
   input wire logic ram_ext_i,
   input wire logic same_bank_i,
   input wire logic [mad_pkg::WS_W-1:0] wait_states_i,
   input wire logic ctrl_we_i,
   input wire logic [mad_pkg::CTRL_W-1:0] ctrl_wdata_i,
   // Status and results
   input wire logic ready_o,
   input wire logic done_o,
   input wire logic table_ptr_inc_o,
   input wire logic ram_we_o,
   input wire logic [mad_pkg::ACC_W-1:0] acc0_o,
   input wire logic [mad_pkg::CTRL_W-1:0] ctrl_o
);
   logic take;
   logic noext;
   // Accepted instruction with no external access
   assign take = instr_valid_i && ready_o;
   assign noext = !pc_ext_i && !table_ext_i && !ram_ext_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   AST_NOXFER_ONE: assert property (take && xfer_i == mad_pkg::X_NONE && noext |=> done_o && ready_o)
      else $error("no-transfer instruction not done in one cycle");
   AST_STORE_TWO: assert property (take && (xfer_i == mad_pkg::X_ST_A || xfer_i == mad_pkg::X_ST_Y) && noext
      |=> ram_we_o && !ready_o ##1 done_o)
      else $error("store not done in two cycles");
   AST_WAIT: assert property (take && xfer_i == mad_pkg::X_NONE && pc_ext_i && !table_ext_i && !ram_ext_i
      && wait_states_i == 4'h3 |=> !done_o [*3] ##1 done_o)
      else $error("wait-states not added");
   AST_BANK: assert property (take && xfer_i == mad_pkg::X_YH_X && same_bank_i && noext
      |=> !done_o ##1 done_o)
      else $error("bank conflict cycle not added");
   AST_AH_CLEAR: assert property (take && xfer_i == mad_pkg::X_AH && !xfer_acc_i && !ctrl_o[0]
      |=> acc0_o == {{4{$past(ram_rdata_i[15])}}, $past(ram_rdata_i), 16'h0000})
      else $error("upper load did not clear lower half");
   AST_AH_KEEP: assert property (take && xfer_i == mad_pkg::X_AH && !xfer_acc_i && ctrl_o[0]
      |=> acc0_o[15:0] == $past(acc0_o[15:0]))
      else $error("inhibited lower half changed");
   AST_MIRROR_INC: assert property (take && ctrl_o[2] && xfer_i == mad_pkg::X_YH_X |=> table_ptr_inc_o)
      else $error("table pointer not incremented");
   AST_CTRL: assert property (ctrl_we_i |=> ctrl_o == $past(ctrl_wdata_i))
      else $error("control register not loaded");
   // Main scenarios reached
   COV_STORE: cover property (take && xfer_i == mad_pkg::X_ST_A);
   COV_MIRROR: cover property (take && ctrl_o[2] && xfer_i == mad_pkg::X_YH);
   COV_WAIT: cover property (take && pc_ext_i);
endmodule // mad_chk

bind mad_datapath mad_chk i_mad_chk (.clk_i(clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
   .func_i(func_i), .xfer_i(xfer_i), .xfer_acc_i(xfer_acc_i), .ram_rdata_i(ram_rdata_i), .pc_ext_i(pc_ext_i),
   .table_ext_i(table_ext_i), .ram_ext_i(ram_ext_i), .same_bank_i(same_bank_i), .wait_states_i(wait_states_i),
   .ctrl_we_i(ctrl_we_i), .ctrl_wdata_i(ctrl_wdata_i), .ready_o(ready_o), .done_o(done_o),
   .table_ptr_inc_o(table_ptr_inc_o), .ram_we_o(ram_we_o), .acc0_o(acc0_o), .ctrl_o(ctrl_o));

// file: mad_mem_model.sv
`timescale 1ns/1ps
module mad_mem_model (
   // Clock
   input wire logic clk_i,
   // Access from the datapath
   input wire logic [2:0] ram_addr_i,
   input wire logic ram_we_i,
   input wire logic [mad_pkg::WORD_W-1:0] ram_wdata_i,
   // Read data
   output logic [mad_pkg::WORD_W-1:0] ram_rdata_o,
   output logic [mad_pkg::WORD_W-1:0] table_rdata_o
);
   logic [15:0] mem [8];
   // Preset words used by the scenarios
   initial mem = '{16'hFFFD, 16'h0005, 16'h0006, 16'h0007, 16'h1234, 16'h5678, 16'h8000, 16'h0000};
   // Table word differs from all RAM words so a mirrored fetch shows
   assign ram_rdata_o = mem[ram_addr_i];
   assign table_rdata_o = 16'h000B;
   // Store port
   always @(posedge clk_i) begin
      if (ram_we_i) begin
         mem[ram_addr_i] <= ram_wdata_i;
      end
   end
endmodule // mad_mem_model

// file: tb_multiply_alu_datapath.sv
`timescale 1ns/1ps
module tb_multiply_alu_datapath;
   logic clk_i = 1'b0, srst_i = 1'b1, instr_valid_i = 1'b0, mul_i = 1'b0, src_acc_i = 1'b0, dst_acc_i = 1'b0;
   logic xfer_acc_i = 1'b0, pc_ext_i = 1'b0, table_ext_i = 1'b0, ram_ext_i = 1'b0, same_bank_i = 1'b0;
   logic counter_cond_i = 1'b0, random_bit_i = 1'b0, bmu_update_i = 1'b0, ctrl_we_i = 1'b0;
   logic [2:0] ram_addr = 3'h0, bmu_flags_i = 3'h0, ctrl_wdata_i = 3'h0;
   logic [3:0] wait_states_i = 4'h0;
   mad_pkg::mad_func_t func_i = mad_pkg::F_NONE;
   mad_pkg::mad_opw_t opw_i = mad_pkg::OPW_16;
   mad_pkg::mad_cond_t cond_i = mad_pkg::C_TRUE;
   mad_pkg::mad_xfer_t xfer_i = mad_pkg::X_NONE;
   logic [15:0] ram_rdata, table_rdata, ram_wdata_o;
   logic ready_o, done_o, table_ptr_inc_o, ram_we_o, tpi, rwe;
   logic [35:0] acc0_o, acc1_o;
   logic [31:0] prod_o;
   logic [2:0] flags_o, ctrl_o;
   int errors = 0, checked = 0;
   // ***********************************************
   // Clock, design and memories
   // ***********************************************
   always #12.5 clk_i = ~clk_i;
   mad_datapath i_mad_datapath (.clk_i(clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .func_i(func_i),
      .mul_i(mul_i), .src_acc_i(src_acc_i), .dst_acc_i(dst_acc_i), .opw_i(opw_i), .cond_i(cond_i),
      .xfer_i(xfer_i), .xfer_acc_i(xfer_acc_i), .ram_rdata_i(ram_rdata), .table_rdata_i(table_rdata),
      .pc_ext_i(pc_ext_i), .table_ext_i(table_ext_i), .ram_ext_i(ram_ext_i), .same_bank_i(same_bank_i),
      .wait_states_i(wait_states_i), .counter_cond_i(counter_cond_i), .random_bit_i(random_bit_i),
      .bmu_update_i(bmu_update_i), .bmu_flags_i(bmu_flags_i), .ctrl_we_i(ctrl_we_i), .ctrl_wdata_i(ctrl_wdata_i),
      .ready_o(ready_o), .done_o(done_o), .table_ptr_inc_o(table_ptr_inc_o), .ram_we_o(ram_we_o),
      .ram_wdata_o(ram_wdata_o), .acc0_o(acc0_o), .acc1_o(acc1_o), .prod_o(prod_o), .flags_o(flags_o),
      .ctrl_o(ctrl_o));
   mad_mem_model i_mad_mem_model (.clk_i(clk_i), .ram_addr_i(ram_addr), .ram_we_i(ram_we_o),
      .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata), .table_rdata_o(table_rdata));
   // ***********************************************
   // Shared tasks
   // ***********************************************
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One instruction, then count cycles up to its completion
   task automatic op(input mad_pkg::mad_func_t f, input logic m, input logic s, input logic d,
      input mad_pkg::mad_opw_t w, input mad_pkg::mad_xfer_t x, input logic [2:0] a, input int n);
      int k;
      @(posedge clk_i);
      #1 func_i = f;
      mul_i = m;
      src_acc_i = s;
      dst_acc_i = d;
      opw_i = w;
      xfer_i = x;
      ram_addr = a;
      instr_valid_i = 1'b1;
      @(posedge clk_i);
      #1 instr_valid_i = 1'b0;
      tpi = table_ptr_inc_o;
      rwe = ram_we_o;
      k = 1;
      while (done_o !== 1'b1 && k < 40) begin
         @(posedge clk_i);
         #1 k++;
      end
      chk("cycles", 36'(n), 36'(k));
   endtask
   task automatic set_ctrl(input logic [2:0] v);
      @(posedge clk_i);
      #1 ctrl_we_i = 1'b1;
      ctrl_wdata_i = v;
      @(posedge clk_i);
      #1 ctrl_we_i = 1'b0;
      chk("ctrl", 36'(v), 36'(ctrl_o));
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_reset;
      chk("ready", 36'h1, 36'(ready_o));
      chk("ctrl", 36'h0, 36'(ctrl_o));
   endtask
   task automatic t_mul;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_YH, 3'h0, 1);
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_X, 3'h0, 1);
      op(mad_pkg::F_MUL, 1'b1, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("prod", 36'hFFFFFFDF, 36'(prod_o));
   endtask
   task automatic t_alu;
      op(mad_pkg::F_LDP, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc0", 36'hFFFFFFFDF, acc0_o);
      op(mad_pkg::F_ADDY, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc0", 36'hFFFFCFFDF, acc0_o);
      op(mad_pkg::F_XORY, 1'b0, 1'b0, 1'b1, mad_pkg::OPW_36, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc1", 36'hFFFFCFFDF, acc1_o);
   endtask
   task automatic t_timing;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_ST_A, 3'h7, 2);
      chk("ram_we", 36'h1, 36'(rwe));
      chk("ram_wdata", 36'h0FFFC, 36'(ram_wdata_o));
      wait_states_i = 4'h3;
      ram_ext_i = 1'b1;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_YH, 3'h0, 4);
      ram_ext_i = 1'b0;
      pc_ext_i = 1'b1;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 4);
      pc_ext_i = 1'b0;
      same_bank_i = 1'b1;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_YH_X, 3'h0, 2);
      same_bank_i = 1'b0;
   endtask
   task automatic t_clear;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_AH, 3'h4, 1);
      chk("acc0", 36'h012340000, acc0_o);
      set_ctrl(3'h1);
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_AL, 3'h5, 1);
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_AH, 3'h6, 1);
      chk("acc0", 36'hF80005678, acc0_o);
   endtask
   task automatic t_mirror;
      set_ctrl(3'h4);
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_YH, 3'h1, 1);
      op(mad_pkg::F_LDP, 1'b1, 1'b0, 1'b1, mad_pkg::OPW_16, mad_pkg::X_YH, 3'h2, 1);
      chk("prod", 36'h19, 36'(prod_o));
      op(mad_pkg::F_LDP, 1'b1, 1'b0, 1'b1, mad_pkg::OPW_16, mad_pkg::X_YH, 3'h3, 1);
      chk("prod", 36'h24, 36'(prod_o));
      chk("acc1", 36'h19, acc1_o);
      same_bank_i = 1'b1;
      op(mad_pkg::F_NONE, 1'b0, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_YH_X, 3'h3, 2);
      same_bank_i = 1'b0;
      chk("tbl_inc", 36'h1, 36'(tpi));
      op(mad_pkg::F_MUL, 1'b1, 1'b0, 1'b0, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("prod", 36'h31, 36'(prod_o));
   endtask
   task automatic t_cond;
      cond_i = mad_pkg::C_CTR;
      op(mad_pkg::S_NEG, 1'b0, 1'b1, 1'b1, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc1", 36'h19, acc1_o);
      counter_cond_i = 1'b1;
      op(mad_pkg::S_NEG, 1'b0, 1'b1, 1'b1, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc1", 36'hFFFFFFFE7, acc1_o);
      cond_i = mad_pkg::C_RAND;
      random_bit_i = 1'b1;
      op(mad_pkg::S_INC, 1'b0, 1'b1, 1'b1, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc1", 36'hFFFFFFFE8, acc1_o);
      chk("flags", 36'h2, 36'(flags_o));
      // Plus condition fails on a negative result, so nothing changes
      cond_i = mad_pkg::C_PL;
      op(mad_pkg::S_INC, 1'b0, 1'b1, 1'b1, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc1", 36'hFFFFFFFE8, acc1_o);
      // Flags loaded from the bit manipulation unit drive the next condition
      @(posedge clk_i);
      #1 bmu_flags_i = 3'h1;
      bmu_update_i = 1'b1;
      @(posedge clk_i);
      #1 bmu_update_i = 1'b0;
      chk("flags", 36'h1, 36'(flags_o));
      cond_i = mad_pkg::C_EQ;
      op(mad_pkg::S_INC, 1'b0, 1'b1, 1'b1, mad_pkg::OPW_16, mad_pkg::X_NONE, 3'h0, 1);
      chk("acc1", 36'hFFFFFFFE9, acc1_o);
   endtask
   task automatic results;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ***********************************************
   // Main sequence and watchdog
   // ***********************************************
   initial begin
      repeat (6) @(posedge clk_i);
      #1 srst_i = 1'b0;
      t_reset();
      t_mul();
      t_alu();
      t_timing();
      t_clear();
      t_mirror();
      t_cond();
      results();
   end
   initial begin
      #200000;
      errors++;
      results();
   end
endmodule // tb_multiply_alu_datapath
